// [src/periodic_timer.sv]
// Periodic timer: compare, timer/counter, PWM, single pulse and capture.
// Assumes a one-cycle register port and asynchronous pins on timer_io/clk.
//
// Contract
// - op_mode_sel 11 selects timer/counter mode.
// - Timer/counter counts and flags like compare mode, pin undriven.
// - op_mode_sel 10 with pin_action_sel 10 selects PWM.
// - PWM: period match clears counter; compare A match sets duty.
// - PWM period equals period_value, zero gives 1024; duty equals A.
// - Compare A at or above the period gives 100% duty.
// - PWM sets a_match_flag and p_match_flag on their matches.
// - output_level_sel picks polarity; pin_action_sel enables or forces.
// - output_invert inverts the waveform at the pin.
// - PWM counting runs for pin_action 00 or 01; clear source ignored.
// - op_mode_sel 10 and pin_action_sel 11 select single pulse.
// - Single pulse: timer clock pin edge sets timer_run.
// - Rising timer_run starts counter and pulse leading edge.
// - A match clears timer_run, ends pulse, raises flag; sw clear of run ends it, no flag.
// - Single pulse counter zeroed only on run rise; period ignored.
// - op_mode_sel 01 selects capture; run starts the counter.
// - Capture source is io pin or clock pin by capture_source_sel.
// - pin_action picks rising, falling, both edges; 11 blocks capture.
// - Capture edge copies counter into compare A and raises flag.
// - Capture counter free-runs until timer_run falls.
// - Capture: period match zeroes counter, raises flag; zero is full.
// - Capture ignores clear source, level, invert; no output drive.
// - capture_source_sel 0 is io pin, 1 is clock pin.
// - Counter, period and compare A are 10 bits, low byte plus two.
// - output_level_sel 0 active low, 1 active high.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/100ps
`include "periodic_timer_defines.svh"

module periodic_timer #(
    parameter int CLK_DIV = 1
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    // Register port
    input  wire logic [`PT_ADDR_W-1:0]   reg_addr,
    input  wire logic [`PT_DATA_W-1:0]   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`PT_DATA_W-1:0]   reg_rdata,
    // Timer pins
    input  wire logic                    timer_io_in,
    output logic                         timer_io_out,
    output logic                         timer_io_oe,
    input  wire logic                    timer_clk_in,
    // Status
    output logic                         a_match_flag,
    output logic                         p_match_flag
);
    // Elaboration check: the divider counter is 16 bits wide
    if (CLK_DIV < 1 || CLK_DIV > 65536) begin : g_bad_div
        $error("CLK_DIV out of range");
    end

    localparam logic [15:0] DIV_LAST = 16'(CLK_DIV - 1);

    function automatic logic edge_hit(input logic [1:0] act,
                                      input logic rise, input logic fall);
        case (act)
            2'h0:    edge_hit = rise;
            2'h1:    edge_hit = fall;
            2'h2:    edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // Pin synchronisers
    logic [2:0] io_sync;
    logic [2:0] ck_sync;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            io_sync <= 3'h0;
            ck_sync <= 3'h0;
        end else begin
            io_sync <= {io_sync[1:0], timer_io_in};
            ck_sync <= {ck_sync[1:0], timer_clk_in};
        end
    end

    // State
    logic [15:0]              div_cnt, next_div_cnt;
    logic [`PT_CNT_W-1:0]     cnt, next_cnt;
    logic [`PT_CNT_W-1:0]     compare_a_value, next_compare_a_value;
    logic [`PT_CNT_W-1:0]     period_value, next_period_value;
    logic [`PT_DATA_W-1:0]    timer_ctrl1, next_timer_ctrl1;
    logic                     timer_run, next_timer_run;
    logic                     run_q;
    logic                     out_state, next_out_state;
    logic                     next_a_flag, next_p_flag;
    logic                     next_io_out, next_io_oe;
    logic [`PT_DATA_W-1:0]    next_rdata;

    // Decoded controls and events
    periodic_timer_pkg::op_mode_e op_mode_sel;
    logic [1:0]               pin_action_sel;
    logic                     output_level_sel, output_invert;
    logic                     capture_source_sel, clear_source_sel;
    logic                     tick, run_rise, a_hit, p_hit;
    logic                     a_match, p_match, cap_fire, sp_mode, sp_set;
    logic                     is_cmp, clr_on_a, pwm_on, lvl;
    logic                     io_rise, io_fall, ck_rise, ck_fall;
    logic [`PT_CNT_W-1:0]     cnt_inc;

    always_comb begin
        op_mode_sel = periodic_timer_pkg::op_mode_e'(
            timer_ctrl1[`PT_MODE_HI:`PT_MODE_LO]);
        pin_action_sel     = timer_ctrl1[`PT_ACT_HI:`PT_ACT_LO];
        output_level_sel   = timer_ctrl1[`PT_OLVL_BIT];
        output_invert      = timer_ctrl1[`PT_INV_BIT];
        capture_source_sel = timer_ctrl1[`PT_CAPSRC_BIT];
        clear_source_sel   = timer_ctrl1[`PT_CLRSRC_BIT];
        io_rise = io_sync[1] & ~io_sync[2];
        io_fall = ~io_sync[1] & io_sync[2];
        ck_rise = ck_sync[1] & ~ck_sync[2];
        ck_fall = ~ck_sync[1] & ck_sync[2];

        tick     = (div_cnt == 16'h0000);
        run_rise = timer_run & ~run_q;
        cnt_inc  = cnt + `PT_CNT_W'(1);
        // Compare every cycle, one-cycle match pulses on the count tick
        a_hit = tick & timer_run & ~run_rise &
                (cnt_inc == compare_a_value);
        p_hit = tick & timer_run & ~run_rise &
                (cnt_inc == period_value);
        // Timer/counter behaves as compare mode
        is_cmp   = (op_mode_sel == periodic_timer_pkg::MODE_CMP) ||
                   (op_mode_sel ==
                    periodic_timer_pkg::MODE_TMR);
        sp_mode  = (op_mode_sel == periodic_timer_pkg::MODE_PWM) &&
                   (pin_action_sel ==
                    periodic_timer_pkg::ACT_TOGGLE);
        clr_on_a = is_cmp & clear_source_sel;
        a_match  = a_hit & (op_mode_sel != periodic_timer_pkg::MODE_CAP);
        p_match  = p_hit & ~clr_on_a & ~sp_mode;
        // Capture source and edge choice
        cap_fire = (op_mode_sel == periodic_timer_pkg::MODE_CAP) & timer_run &
                   (capture_source_sel ?
                    edge_hit(pin_action_sel, ck_rise, ck_fall) :
                    edge_hit(pin_action_sel, io_rise, io_fall));
        sp_set = sp_mode & ck_rise;

        next_div_cnt = tick ? DIV_LAST : div_cnt - 16'h0001;

        // Counter; zero on run rise, 0 period wraps through 1023
        next_cnt = cnt;
        if (run_rise) begin
            next_cnt = `PT_VAL_RST;
        end else if (tick && timer_run) begin
            if (p_match || (a_match && clr_on_a)) begin
                next_cnt = `PT_VAL_RST;
            end else begin
                next_cnt = cnt_inc;
            end
        end

        // Software writes
        next_timer_ctrl1     = timer_ctrl1;
        next_compare_a_value = compare_a_value;
        next_period_value    = period_value;
        next_timer_run       = timer_run;
        next_a_flag          = a_match_flag;
        next_p_flag          = p_match_flag;
        if (reg_wr) begin
            case (reg_addr)
                `PT_ADDR_CTRL0: begin
                    next_timer_run = reg_wdata[`PT_RUN_BIT];
                    next_a_flag = a_match_flag & ~reg_wdata[`PT_FLAG_A_BIT];
                    next_p_flag = p_match_flag & ~reg_wdata[`PT_FLAG_P_BIT];
                end
                `PT_ADDR_CTRL1: next_timer_ctrl1 = reg_wdata;
                `PT_ADDR_A_LO:  next_compare_a_value[`PT_LO_W-1:0] = reg_wdata;
                `PT_ADDR_A_HI: begin
                    next_compare_a_value[`PT_CNT_W-1:`PT_LO_W] =
                        reg_wdata[`PT_HI_W-1:0];
                end
                `PT_ADDR_P_LO:  next_period_value[`PT_LO_W-1:0] = reg_wdata;
                `PT_ADDR_P_HI: begin
                    next_period_value[`PT_CNT_W-1:`PT_LO_W] =
                        reg_wdata[`PT_HI_W-1:0];
                end
                default: ;
            endcase
        end
        // Hardware events win over software
        if (sp_mode && a_match) begin
            next_timer_run = 1'b0;
        end
        if (sp_set) begin
            next_timer_run = 1'b1;
        end
        if (cap_fire) begin
            next_compare_a_value = cnt;
        end
        if (a_match || cap_fire) begin
            next_a_flag = 1'b1;
        end
        if (p_match) begin
            next_p_flag = 1'b1;
        end

        // Compare-mode pin state
        next_out_state = out_state;
        if (run_rise) begin
            next_out_state = output_level_sel;
        end else if (a_match) begin
            case (pin_action_sel)
                periodic_timer_pkg::ACT_CLEAR:  next_out_state = 1'b0;
                periodic_timer_pkg::ACT_SET:    next_out_state = 1'b1;
                periodic_timer_pkg::ACT_TOGGLE: next_out_state = ~out_state;
                default:                        next_out_state = out_state;
            endcase
        end

        // PWM active from clear until A match, or whole cycle when A >= P and P is nonzero
        pwm_on = (cnt < compare_a_value) ||
                 ((period_value != `PT_VAL_RST) &&
                  (compare_a_value >= period_value));
        case (pin_action_sel)
            periodic_timer_pkg::ACT_SET:
                lvl = pwm_on ? output_level_sel : ~output_level_sel;
            periodic_timer_pkg::ACT_CLEAR: lvl = output_level_sel;
            periodic_timer_pkg::ACT_TOGGLE:
                lvl = timer_run ? output_level_sel : ~output_level_sel;
            default: lvl = ~output_level_sel;
        endcase
        if (op_mode_sel == periodic_timer_pkg::MODE_CMP) begin
            lvl = out_state;
        end
        next_io_out = lvl ^ output_invert;
        // Pin left free in timer/counter and capture modes
        next_io_oe  = (op_mode_sel == periodic_timer_pkg::MODE_CMP) ||
                      (op_mode_sel ==
                       periodic_timer_pkg::MODE_PWM);

        // Read data, valid only in the cycle after the strobe
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `PT_ADDR_CTRL0: begin
                    next_rdata[`PT_RUN_BIT]    = timer_run;
                    next_rdata[`PT_FLAG_A_BIT] = a_match_flag;
                    next_rdata[`PT_FLAG_P_BIT] = p_match_flag;
                end
                `PT_ADDR_CTRL1:  next_rdata = timer_ctrl1;
                `PT_ADDR_CNT_LO: next_rdata = cnt[`PT_LO_W-1:0];
                `PT_ADDR_CNT_HI: begin
                    next_rdata[`PT_HI_W-1:0] = cnt[`PT_CNT_W-1:`PT_LO_W];
                end
                `PT_ADDR_A_LO:   next_rdata = compare_a_value[`PT_LO_W-1:0];
                `PT_ADDR_A_HI: begin
                    next_rdata[`PT_HI_W-1:0] =
                        compare_a_value[`PT_CNT_W-1:`PT_LO_W];
                end
                `PT_ADDR_P_LO:   next_rdata = period_value[`PT_LO_W-1:0];
                `PT_ADDR_P_HI: begin
                    next_rdata[`PT_HI_W-1:0] =
                        period_value[`PT_CNT_W-1:`PT_LO_W];
                end
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt         <= 16'h0000;
            cnt             <= `PT_VAL_RST;
            compare_a_value <= `PT_VAL_RST;
            period_value    <= `PT_VAL_RST;
            timer_ctrl1     <= `PT_CTRL_RST;
            timer_run       <= 1'b0;
            run_q           <= 1'b0;
            out_state       <= 1'b0;
            a_match_flag    <= 1'b0;
            p_match_flag    <= 1'b0;
            timer_io_out    <= 1'b0;
            timer_io_oe     <= 1'b0;
            reg_rdata       <= '0;
        end else begin
            div_cnt         <= next_div_cnt;
            cnt             <= next_cnt;
            compare_a_value <= next_compare_a_value;
            period_value    <= next_period_value;
            timer_ctrl1     <= next_timer_ctrl1;
            timer_run       <= next_timer_run;
            run_q           <= timer_run;
            out_state       <= next_out_state;
            a_match_flag    <= next_a_flag;
            p_match_flag    <= next_p_flag;
            timer_io_out    <= next_io_out;
            timer_io_oe     <= next_io_oe;
            reg_rdata       <= next_rdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_tmr_no_drive;
        op_mode_sel == periodic_timer_pkg::MODE_TMR |=> !timer_io_oe;
    endproperty
    a_tmr_no_drive: assert property (p_tmr_no_drive)
        else $error("pin driven in timer/counter mode");

    property p_pwm_clear;
        op_mode_sel == periodic_timer_pkg::MODE_PWM && !sp_mode && p_match
        |=> cnt == `PT_VAL_RST;
    endproperty
    a_pwm_clear: assert property (p_pwm_clear)
        else $error("period match did not clear counter");

    property p_flag_a;
        a_match |=> a_match_flag;
    endproperty
    a_flag_a: assert property (p_flag_a)
        else $error("a_match_flag not set");

    property p_flag_p;
        p_match |=> p_match_flag;
    endproperty
    a_flag_p: assert property (p_flag_p)
        else $error("p_match_flag not set");

    property p_sp_stop;
        sp_mode && a_match && !sp_set
        |=> !timer_run ##1
            timer_io_out == ($past(~output_level_sel) ^ $past(output_invert));
    endproperty
    a_sp_stop: assert property (p_sp_stop)
        else $error("single pulse not ended by A match");

    property p_sp_start;
        sp_mode && run_rise |=> cnt == `PT_VAL_RST;
    endproperty
    a_sp_start: assert property (p_sp_start)
        else $error("counter not zeroed at pulse start");

    property p_cap_copy;
        cap_fire |=> compare_a_value == $past(cnt) && a_match_flag;
    endproperty
    a_cap_copy: assert property (p_cap_copy)
        else $error("capture did not copy counter");

    property p_cap_none;
        op_mode_sel == periodic_timer_pkg::MODE_CAP &&
        pin_action_sel == periodic_timer_pkg::ACT_TOGGLE |-> !cap_fire;
    endproperty
    a_cap_none: assert property (p_cap_none)
        else $error("capture with edges disabled");

    property p_cap_no_drive;
        op_mode_sel == periodic_timer_pkg::MODE_CAP |=> !timer_io_oe;
    endproperty
    a_cap_no_drive: assert property (p_cap_no_drive)
        else $error("pin driven in capture mode");

    sequence s_pwm_full;
        op_mode_sel == periodic_timer_pkg::MODE_PWM &&
        pin_action_sel == periodic_timer_pkg::ACT_SET &&
        period_value != `PT_VAL_RST && compare_a_value >= period_value;
    endsequence
    property p_pwm_full;
        s_pwm_full |=> timer_io_out == ($past(output_level_sel) ^
                                        $past(output_invert));
    endproperty
    a_pwm_full: assert property (p_pwm_full)
        else $error("full duty not held");

    c_pwm_wrap: cover property (
        op_mode_sel == periodic_timer_pkg::MODE_PWM && p_match);
    c_sp_end:   cover property (sp_mode && a_match);
    c_capture:  cover property (cap_fire);
    c_sp_pin:   cover property (sp_set ##1 timer_run);
endmodule : periodic_timer

// [include/periodic_timer_defines.svh]
// Offsets, field positions and reset values of the periodic timer.
// Included by the package users; definitions only.
`ifndef PERIODIC_TIMER_DEFINES_SVH
`define PERIODIC_TIMER_DEFINES_SVH

`define PT_CNT_W        10
`define PT_LO_W         8
`define PT_HI_W         2
`define PT_ADDR_W       3
`define PT_DATA_W       8

`define PT_ADDR_CTRL0   3'h0
`define PT_ADDR_CTRL1   3'h1
`define PT_ADDR_CNT_LO  3'h2
`define PT_ADDR_CNT_HI  3'h3
`define PT_ADDR_A_LO    3'h4
`define PT_ADDR_A_HI    3'h5
`define PT_ADDR_P_LO    3'h6
`define PT_ADDR_P_HI    3'h7

`define PT_RUN_BIT      3
`define PT_FLAG_A_BIT   6
`define PT_FLAG_P_BIT   7
`define PT_MODE_HI      7
`define PT_MODE_LO      6
`define PT_ACT_HI       5
`define PT_ACT_LO       4
`define PT_OLVL_BIT     3
`define PT_INV_BIT      2
`define PT_CAPSRC_BIT   1
`define PT_CLRSRC_BIT   0

`define PT_CTRL_RST     8'h00
`define PT_VAL_RST      10'h000

`endif

// [include/periodic_timer_pkg.sv]
// Types shared by the periodic timer.
// Assumes the defines header for widths.
package periodic_timer_pkg;
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } op_mode_e;

    // Pin action code; meaning depends on the mode
    typedef enum logic [1:0] {
        ACT_IDLE   = 2'h0,
        ACT_CLEAR  = 2'h1,
        ACT_SET    = 2'h2,
        ACT_TOGGLE = 2'h3
    } pin_act_e;
endpackage : periodic_timer_pkg

// [dv/pin_partner.sv]
// Far-side model of the timer pins: pulse sources and the pin load.
// Assumes the bench changes its requests just after a rising edge.
`timescale 1ns/100ps
module pin_partner (
    // Design side
    input  wire logic io_out,
    input  wire logic io_oe,
    output logic      timer_io_in,
    output logic      timer_clk_in,
    // Bench requests
    input  wire logic io_src,
    input  wire logic clk_src
);
    // Outside source let go while the timer drives the pin
    assign timer_io_in  = io_oe ? io_out : io_src;
    assign timer_clk_in = clk_src;
endmodule : pin_partner

// [dv/testbench.sv]
// Self-checking bench of the periodic timer modes.
// Assumes the one-cycle register port and the pin model beside it.
`timescale 1ns/100ps
`include "periodic_timer_defines.svh"
module testbench;
    logic                  clk;
    logic                  rst_b;
    logic [`PT_ADDR_W-1:0] reg_addr;
    logic [`PT_DATA_W-1:0] reg_wdata;
    logic [`PT_DATA_W-1:0] reg_rdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic                  io_out;
    logic                  io_oe;
    logic                  io_in;
    logic                  ck_in;
    logic                  io_src;
    logic                  clk_src;
    logic                  a_flag;
    logic                  p_flag;
    logic [7:0]            v1;
    logic [7:0]            v2;
    int                    errors;
    int                    samples_checked;
    int                    k;
    logic [7:0] pc [9] = '{8'hA8, 8'hA8, 8'hA8, 8'hAC, 8'hA0, 8'hA4,
                           8'h88, 8'h98, 8'hA9};
    logic [9:0] pa [9] = '{10'h001, 10'h004, 10'h006, 10'h001, 10'h001,
                           10'h001, 10'h001, 10'h001, 10'h001};
    logic [9:0] pe [9] = '{10'h00A, 10'h028, 10'h028, 10'h01E, 10'h01E,
                           10'h00A, 10'h000, 10'h028, 10'h00A};

    periodic_timer #(.CLK_DIV(1)) periodic_timer_i (
        .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_io_in(io_in),
        .timer_io_out(io_out), .timer_io_oe(io_oe),
        .timer_clk_in(ck_in), .a_match_flag(a_flag),
        .p_match_flag(p_flag)
    );
    pin_partner pin_partner_i (
        .io_out(io_out), .io_oe(io_oe), .timer_io_in(io_in),
        .timer_clk_in(ck_in), .io_src(io_src), .clk_src(clk_src)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    // Stop, clear flags, load mode, A and P, optionally restart
    task cfg(input logic [7:0] c1, input logic [9:0] a,
             input logic [9:0] p, input logic go);
        wr(`PT_ADDR_CTRL0, 8'hC0);
        wr(`PT_ADDR_CTRL1, c1);
        wr(`PT_ADDR_A_LO, a[7:0]);
        wr(`PT_ADDR_A_HI, {6'h00, a[9:8]});
        wr(`PT_ADDR_P_LO, p[7:0]);
        wr(`PT_ADDR_P_HI, {6'h00, p[9:8]});
        if (go) begin
            wr(`PT_ADDR_CTRL0, 8'h08);
        end
        repeat (10) @(posedge clk);
    endtask : cfg

    // Cycles with the pin high over a window
    task hc(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (io_in === 1'b1) c++;
        end
    endtask : hc

    task conclude;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    initial begin
        #200000;
        errors++;
        conclude();
    end

    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        io_src = 1'b0;
        clk_src = 1'b0;
        errors = 0;
        samples_checked = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], v1);
            chk({2'h0, v1}, 10'h000);
        end
        wr(`PT_ADDR_CNT_LO, 8'hFF);
        rd(`PT_ADDR_CNT_LO, v1);
        chk({2'h0, v1}, 10'h000);
        wr(`PT_ADDR_A_HI, 8'hFF);
        rd(`PT_ADDR_A_HI, v1);
        chk({2'h0, v1}, 10'h003);
        // PWM duty, polarity, invert and forced levels at P=4, then duty at P=0
        for (int i = 0; i < 9; i++) begin
            cfg(pc[i], pa[i], 10'h004, 1'b1);
            hc(40, k);
            chk(10'(k), pe[i]);
            chk(10'(k), pe[i]);
        end
        chk({8'h00, a_flag, p_flag}, 10'h003);
        chk({9'h000, io_oe}, 10'h001);
        cfg(8'hA8, 10'h100, 10'h000, 1'b1);
        hc(1024, k);
        chk(10'(k), 10'h100);
        // Compare mode toggles the pin on each A match, period 5
        cfg(8'h38, 10'h003, 10'h005, 1'b1);
        hc(40, k);
        chk(10'(k), 10'h014);
        chk({8'h00, a_flag, p_flag}, 10'h003);
        // Timer/counter mode
        cfg(8'hC0, 10'h003, 10'h008, 1'b1);
        chk({9'h000, io_oe}, 10'h000);
        chk({8'h00, a_flag, p_flag}, 10'h003);
        rd(`PT_ADDR_CNT_LO, v1);
        chk({9'h000, v1 < 8'h08}, 10'h001);
        // Single pulse from the clock pin, P ignored
        cfg(8'hB8, 10'h014, 10'h005, 1'b0);
        @(posedge clk);
        clk_src <= 1'b1;
        hc(60, k);
        chk({9'h000, k >= 19 && k <= 21}, 10'h001);
        chk({9'h000, k >= 19 && k <= 21}, 10'h001);
        rd(`PT_ADDR_CTRL0, v1);
        chk({8'h00, v1[`PT_RUN_BIT], a_flag}, 10'h001);
        @(posedge clk);
        clk_src <= 1'b0;
        wr(`PT_ADDR_CTRL0, 8'h08);
        hc(5, k);
        chk({9'h000, k >= 3}, 10'h001);
        wr(`PT_ADDR_CTRL0, 8'h00);
        repeat (3) @(posedge clk);
        hc(30, k);
        chk(10'(k), 10'h000);
        // Capture on rising io edges; level, invert, clear set
        cfg(8'h4D, 10'h000, 10'h000, 1'b1);
        chk({9'h000, io_oe}, 10'h000);
        fork
            begin
                @(posedge clk);
                io_src <= 1'b1;
                repeat (40) @(posedge clk);
                io_src <= 1'b0;
                repeat (10) @(posedge clk);
                io_src <= 1'b1;
            end
            begin
                repeat (20) @(posedge clk);
                rd(`PT_ADDR_A_LO, v1);
            end
        join
        repeat (20) @(posedge clk);
        rd(`PT_ADDR_A_LO, v2);
        chk({2'h0, 8'(v2 - v1)}, 10'h032);
        chk({9'h000, a_flag}, 10'h001);
        // No captures at pin action 11, counter still running
        cfg(8'h70, 10'h000, 10'h000, 1'b1);
        io_src <= 1'b0;
        repeat (10) @(posedge clk);
        io_src <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`PT_ADDR_A_LO, v1);
        chk({1'b0, a_flag, v1}, 10'h000);
        rd(`PT_ADDR_CNT_LO, v1);
        repeat (10) @(posedge clk);
        rd(`PT_ADDR_CNT_LO, v2);
        chk({2'h0, 8'(v2 - v1)}, 10'h00C);
        // Clock pin as source, period match at 40
        cfg(8'h42, 10'h000, 10'h028, 1'b1);
        @(posedge clk);
        clk_src <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`PT_ADDR_A_LO, v1);
        chk({9'h000, v1 != 8'h00}, 10'h001);
        repeat (40) @(posedge clk);
        chk({8'h00, a_flag, p_flag}, 10'h003);
        // Falling edges only, then both edges, on the io pin
        for (int i = 0; i < 2; i++) begin
            cfg(i ? 8'h60 : 8'h50, 10'h000, 10'h000, 1'b1);
            io_src <= 1'b0;
            repeat (20) @(posedge clk);
            io_src <= 1'b1;
            repeat (20) @(posedge clk);
            rd(`PT_ADDR_A_LO, v1);
            chk({2'h0, v1}, i ? 10'h01F : 10'h00B);
        end
        conclude();
    end
endmodule : testbench
